// ### rtl/dlic_cfg.svh
// register map, reset values and field positions of the interrupt controller
`ifndef DLIC_CFG_SVH
`define DLIC_CFG_SVH
`define DLIC_A_N_MSTA   32'hffff_0000
`define DLIC_A_N_RAW    32'hffff_0004
`define DLIC_A_N_EN     32'hffff_0008
`define DLIC_A_N_CLR    32'hffff_000c
`define DLIC_A_PGM      32'hffff_0010
`define DLIC_A_VBASE    32'hffff_0014
`define DLIC_A_NEST     32'hffff_0018
`define DLIC_A_N_VEC    32'hffff_001c
`define DLIC_A_PRIO0    32'hffff_0020
`define DLIC_A_PRIO1    32'hffff_0024
`define DLIC_A_PRIO2    32'hffff_0028
`define DLIC_A_F_MSTA   32'hffff_0100
`define DLIC_A_F_RAW    32'hffff_0104
`define DLIC_A_F_EN     32'hffff_0108
`define DLIC_A_F_CLR    32'hffff_010c
`define DLIC_A_F_VEC    32'hffff_011c
`define DLIC_RST_WORD   32'h0000_0000
`define DLIC_SRC_MASK   32'h000f_fc78
`define DLIC_PGM_WMASK  32'h0000_0006
`define DLIC_VBASE_MASK 32'h0000_ffff
`define DLIC_NEST_WMASK 32'h0000_0003
`define DLIC_PRIO0_MASK 32'h0777_7070
`define DLIC_PRIO1_MASK 32'h7777_7700
`define DLIC_PRIO2_MASK 32'h0000_7777
`define DLIC_BIT_ANY    0
`define DLIC_BIT_PGM    1
`define DLIC_PGM_N_BIT  1
`define DLIC_PGM_F_BIT  2
`define DLIC_NEST_N_BIT 0
`define DLIC_NEST_F_BIT 1
`define DLIC_VEC_IDX_LSB  2
`define DLIC_VEC_BASE_LSB 7
`define DLIC_LEVELS     8
`endif

// ### rtl/dlic_pkg.sv
// types shared by the interrupt controller
package dlic_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } dlic_apb_req_t;
  // result of the priority search: found, level, source index
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [4:0] idx;
  } dlic_pick_t;
endpackage : dlic_pkg

// ### rtl/dlic_top.sv
// dual-line interrupt controller with apb register access
//
// How it works
// - each source owns one fixed bit everywhere
// - every source maskable alone on both paths
// - normal request is or of normal masked
// - raw status follows source lines, read only
// - enable write sets ones, zeros ignored
// - enable-clear write clears ones, write only
// - normal masked equals raw and enable above bit 1
// - standard mode has no priority or vector
// - fast path mirrors normal register set
// - fast enable-clear clears written ones
// - fast masked equals raw and enable above bit 1
// - fast request ors masked bits 31..1
// - enabling one path disables other path
// - programmed interrupts bypass all enable masks
// - config bit 2 drives fast bit 1
// - config bit 1 drives normal bit 1
// - nesting bits enable vectored prioritised handling
// - nesting up to eight priority levels
// - fast request silences nested normal request
// - each source has 3-bit priority field
// - vector shows best source and base
`timescale 1ns/1ps
`include "dlic_cfg.svh"
module dlic_top
  import dlic_pkg::*;
(
  input  wire logic          CLK_SYS_I,  // 100 MHz system clock
  input  wire logic          RST_N_I,    // async reset, active low
  input  wire logic          CE_I,       // clock enable, freezes state
  input  wire dlic_apb_req_t APB_I,      // apb request group
  input  wire logic [31:0]   SRC_REQ_I,  // peripheral request lines
  output logic [31:0]        PRDATA_O,   // apb read data
  output logic               PREADY_O,   // apb ready
  output logic               PSLVERR_O,  // apb error, unmapped address
  output logic               IRQ_O,      // normal request to core
  output logic               FIQ_O       // fast request to core
);

  // priority field position of a source inside {prio2,prio1,prio0}
  function automatic logic [6:0] prio_pos(input int unsigned i);
    case (i)
      1:       prio_pos = 7'd4;
      3:       prio_pos = 7'd12;
      4:       prio_pos = 7'd16;
      5:       prio_pos = 7'd20;
      6:       prio_pos = 7'd24;
      10:      prio_pos = 7'd40;
      11:      prio_pos = 7'd44;
      12:      prio_pos = 7'd48;
      13:      prio_pos = 7'd52;
      14:      prio_pos = 7'd56;
      15:      prio_pos = 7'd60;
      16:      prio_pos = 7'd64;
      17:      prio_pos = 7'd68;
      18:      prio_pos = 7'd72;
      19:      prio_pos = 7'd76;
      default: prio_pos = 7'd0;
    endcase
  endfunction : prio_pos

  // best pending source: lowest level wins, lower bit wins a tie;
  // bit 0 is only the fast summary and never takes part
  function automatic dlic_pick_t pick(input logic [31:0] pend,
                                      input logic [95:0] prio);
    dlic_pick_t r;
    logic [2:0] lv;
    r = '0;
    lv = 3'd0;
    for (int i = 31; i >= 1; i--) begin
      lv = prio[prio_pos(i) +: 3];
      if (pend[i] && (!r.valid || lv <= r.level)) begin
        r.valid = 1'b1;
        r.level = lv;
        r.idx   = 5'(i);
      end
    end
    return r;
  endfunction : pick

  // lowest level currently in service, 8 when none
  // the stack is one bit per level, so a level can only nest once
  function automatic logic [3:0] cur_level(input logic [7:0] isr);
    logic [3:0] c;
    c = 4'd8;
    for (int i = 7; i >= 0; i--) begin
      if (isr[i]) begin
        c = 4'(i);
      end
    end
    return c;
  endfunction : cur_level

  // software-visible state, plus the in-service stacks that software cannot read
  // masks are not trimmed to the used bits: software reads back
  // what it wrote, and the unused raw bits are zero anyway
  logic [31:0] en_n;        // normal enable mask
  logic [31:0] en_f;        // fast enable mask
  logic [31:0] pgm_cfg;     // programmed interrupt config
  logic [31:0] nest_ctl;    // nesting control
  logic [31:0] vbase;       // vector table base
  logic [31:0] prio0;       // priority fields, word 0
  logic [31:0] prio1;       // priority fields, word 1
  logic [31:0] prio2;       // priority fields, word 2
  logic [7:0]  isr_n;       // normal levels in service
  logic [7:0]  isr_f;       // fast levels in service

  // apb decode; a transfer is taken on its first access cycle
  // and ends one edge later, so every access has one wait state
  wire logic acc     = APB_I.psel && APB_I.penable;
  wire logic take    = acc && !PREADY_O;            // answer next edge
  wire logic commit  = acc && PREADY_O;             // transfer ends
  wire logic wr      = commit && APB_I.pwrite;
  wire logic rd      = commit && !APB_I.pwrite;
  wire logic [31:0] a = APB_I.paddr;
  wire logic [31:0] wd = APB_I.pwdata;
  wire logic wr_en_n  = wr && a == `DLIC_A_N_EN;
  wire logic wr_clr_n = wr && a == `DLIC_A_N_CLR;
  wire logic wr_en_f  = wr && a == `DLIC_A_F_EN;
  wire logic wr_clr_f = wr && a == `DLIC_A_F_CLR;

  // raw and masked status
  wire logic [31:0] src   = SRC_REQ_I & `DLIC_SRC_MASK;
  wire logic pgm_n = pgm_cfg[`DLIC_PGM_N_BIT];
  wire logic pgm_f = pgm_cfg[`DLIC_PGM_F_BIT];
  // bit 1 stays outside the enables: programmed requests are unmaskable
  wire logic [31:0] msk_f_hi =
    (src & en_f) | (32'(pgm_f) << `DLIC_BIT_PGM);
  wire logic fast_any = |msk_f_hi[31:1];
  wire logic [31:0] raw_n = src | (32'(pgm_n) << `DLIC_BIT_PGM)
                          | 32'(fast_any);
  wire logic [31:0] raw_f = src | (32'(pgm_f) << `DLIC_BIT_PGM)
                          | 32'(fast_any);
  wire logic [31:0] msk_n = (src & en_n)
                          | (32'(pgm_n) << `DLIC_BIT_PGM)
                          | 32'(fast_any);
  wire logic [31:0] msk_f = msk_f_hi | 32'(fast_any);

  // vectored search and nesting gate
  wire logic [95:0] prio_all = {prio2, prio1, prio0};
  wire dlic_pick_t  best_n   = pick(msk_n, prio_all);
  wire dlic_pick_t  best_f   = pick(msk_f, prio_all);
  wire logic nest_n = nest_ctl[`DLIC_NEST_N_BIT];
  wire logic nest_f = nest_ctl[`DLIC_NEST_F_BIT];
  wire logic [3:0] cur_n = cur_level(isr_n);
  wire logic [3:0] cur_f = cur_level(isr_f);
  // a source preempts only a strictly lower-priority level
  wire logic go_n = best_n.valid && {1'b0, best_n.level} < cur_n;
  wire logic go_f = best_f.valid && {1'b0, best_f.level} < cur_f;
  wire logic [31:0] vec_n = (vbase << `DLIC_VEC_BASE_LSB)
    | (32'(best_n.idx) << `DLIC_VEC_IDX_LSB);
  wire logic [31:0] vec_f = (vbase << `DLIC_VEC_BASE_LSB)
    | (32'(best_f.idx) << `DLIC_VEC_IDX_LSB);

  // standard mode: plain or of masked bits, no encoder involved
  wire logic next_fiq = nest_f ? go_f : fast_any;
  wire logic next_irq = nest_n ? (go_n && !fast_any)
                               : |msk_n;

  // enable masks: set by enable write, other path and clear win
  wire logic [31:0] next_en_n =
    (en_n | (wr_en_n ? wd : '0))
    & ~(wr_clr_n ? wd : '0)
    & ~(wr_en_f ? wd : '0);
  wire logic [31:0] next_en_f =
    (en_f | (wr_en_f ? wd : '0))
    & ~(wr_clr_f ? wd : '0)
    & ~(wr_en_n ? wd : '0);

  // read of a vector pushes the level, write to it pops the top one
  wire logic push_n = rd && a == `DLIC_A_N_VEC && nest_n && go_n;
  wire logic push_f = rd && a == `DLIC_A_F_VEC && nest_f && go_f;
  wire logic pop_n  = wr && a == `DLIC_A_N_VEC && cur_n < 4'd8;
  wire logic pop_f  = wr && a == `DLIC_A_F_VEC && cur_f < 4'd8;
  wire logic [7:0] next_isr_n = (isr_n
    & ~(pop_n ? 8'(1) << cur_n[2:0] : 8'd0))
    | (push_n ? 8'(1) << best_n.level : 8'd0);
  wire logic [7:0] next_isr_f = (isr_f
    & ~(pop_f ? 8'(1) << cur_f[2:0] : 8'd0))
    | (push_f ? 8'(1) << best_f.level : 8'd0);

  // read mux; clear registers read back as zero
  logic [31:0] rdata;
  logic        mapped;
  always_comb begin
    mapped = 1'b1;
    case (a)
      `DLIC_A_N_MSTA: rdata = msk_n;
      `DLIC_A_N_RAW:  rdata = raw_n;
      `DLIC_A_N_EN:   rdata = en_n;
      `DLIC_A_N_CLR:  rdata = '0;
      `DLIC_A_PGM:    rdata = pgm_cfg;
      `DLIC_A_VBASE:  rdata = vbase;
      `DLIC_A_NEST:   rdata = nest_ctl;
      `DLIC_A_N_VEC:  rdata = vec_n;
      `DLIC_A_PRIO0:  rdata = prio0;
      `DLIC_A_PRIO1:  rdata = prio1;
      `DLIC_A_PRIO2:  rdata = prio2;
      `DLIC_A_F_MSTA: rdata = msk_f;
      `DLIC_A_F_RAW:  rdata = raw_f;
      `DLIC_A_F_EN:   rdata = en_f;
      `DLIC_A_F_CLR:  rdata = '0;
      `DLIC_A_F_VEC:  rdata = vec_f;
      default: begin
        rdata  = '0;
        mapped = 1'b0;
      end
    endcase
  end

  // apb answer: one wait state, data and error land with ready
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= `DLIC_RST_WORD;
      PSLVERR_O <= 1'b0;
    end else if (CE_I) begin
      PREADY_O  <= take;
      PRDATA_O  <= (take && !APB_I.pwrite) ? rdata : '0;
      PSLVERR_O <= take && !mapped;
    end
  end

  // enable masks and nesting stacks
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_n  <= `DLIC_RST_WORD;
      en_f  <= `DLIC_RST_WORD;
      isr_n <= '0;
      isr_f <= '0;
    end else if (CE_I) begin
      en_n  <= next_en_n;
      en_f  <= next_en_f;
      isr_n <= next_isr_n;
      isr_f <= next_isr_f;
    end
  end

  // plain read/write configuration; reserved bits stay zero
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pgm_cfg  <= `DLIC_RST_WORD;
      nest_ctl <= `DLIC_RST_WORD;
      vbase    <= `DLIC_RST_WORD;
      prio0    <= `DLIC_RST_WORD;
      prio1    <= `DLIC_RST_WORD;
      prio2    <= `DLIC_RST_WORD;
    end else if (CE_I && wr) begin
      case (a)
        `DLIC_A_PGM:   pgm_cfg  <= wd & `DLIC_PGM_WMASK;
        `DLIC_A_NEST:  nest_ctl <= wd & `DLIC_NEST_WMASK;
        `DLIC_A_VBASE: vbase    <= wd & `DLIC_VBASE_MASK;
        `DLIC_A_PRIO0: prio0    <= wd & `DLIC_PRIO0_MASK;
        `DLIC_A_PRIO1: prio1    <= wd & `DLIC_PRIO1_MASK;
        `DLIC_A_PRIO2: prio2    <= wd & `DLIC_PRIO2_MASK;
        default:       pgm_cfg  <= pgm_cfg;
      endcase
    end
  end

  // request lines to the core, one register stage after status
  // the extra stage keeps both outputs straight off flops, at
  // the cost of one cycle of latency
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
      FIQ_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_O <= next_irq;
      FIQ_O <= next_fiq;
    end
  end

  // checks; they run on the system clock and sleep through reset
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  // a normal enable write with no clear in the same cycle
  sequence s_en_write;
    CE_I && wr_en_n && !wr_clr_n;
  endsequence
  // a fast enable write
  sequence s_fen_write;
    CE_I && wr_en_f;
  endsequence

  // standard normal request is the or of the masked word
  a_irq_or_std: assert property (CE_I && !nest_n |=>
    IRQ_O == $past(|msk_n)) else $error("irq not or of masked");

  // standard fast request ignores the summary bit itself
  a_fiq_or_std: assert property (CE_I && !nest_f |=>
    FIQ_O == $past(|msk_f_hi[31:1])) else $error("fiq not or");

  // every written one lands in the normal mask
  a_en_set_bits: assert property (s_en_write |=>
    (en_n & $past(wd)) == $past(wd)) else $error("enable not set");

  // written zeros never disable a source
  a_en_keep_zero: assert property (CE_I && wr_en_n |=>
    (en_n & ~$past(wd)) == ($past(en_n) & ~$past(wd)))
    else $error("enable zero changed mask");

  // fast clear drops every written one
  a_clr_bits: assert property (CE_I && wr_clr_f |=>
    (en_f & $past(wd)) == '0) else $error("fast clear failed");

  // enabling a fast source drops it from the normal mask
  a_cross_clear: assert property (s_fen_write |=>
    (en_n & $past(wd)) == '0) else $error("cross clear failed");

  // normal masked word is raw and enable above bit 1
  a_masked_and: assert property (
    msk_n[31:2] == (raw_n[31:2] & en_n[31:2]))
    else $error("masked not raw and enable");

  // programmed fast request ignores the fast mask
  a_pgm_unmask: assert property (pgm_f |->
    msk_f[1] && raw_f[1] && msk_f[0]) else $error("programmed fast lost");

  // nested normal handling yields to any fast request
  a_fiq_first: assert property (nest_n && fast_any && CE_I |=>
    !IRQ_O) else $error("normal beat fast");

  // ready comes one cycle after the access and drops again
  a_apb_answer: assert property (take && CE_I |=> PREADY_O ##1 !PREADY_O)
    else $error("apb answer not one cycle");

  // normal clear drops every written one
  a_clr_normal: assert property (CE_I && wr_clr_n |=>
    (en_n & $past(wd)) == '0) else $error("normal clear failed");

  // normal clear leaves unwritten bits alone
  a_clr_keep_rest: assert property (CE_I && wr_clr_n |=>
    (en_n & ~$past(wd)) == ($past(en_n) & ~$past(wd)))
    else $error("normal clear touched other bits");

  // every written one lands in the fast mask
  a_fen_set_bits: assert property (s_fen_write |=>
    (en_f & $past(wd)) == $past(wd)) else $error("fast enable not set");

  // enabling a normal source drops it from the fast mask
  a_cross_fast: assert property (CE_I && wr_en_n |=>
    (en_f & $past(wd)) == '0) else $error("fast cross clear failed");

  // fast masked word is raw and enable above bit 1
  a_fmasked_and: assert property (
    msk_f[31:2] == (raw_f[31:2] & en_f[31:2]))
    else $error("fast masked not raw and enable");

  // programmed normal request ignores the normal mask
  a_pgm_normal: assert property (pgm_n |->
    msk_n[1] && raw_n[1]) else $error("programmed normal lost");

  // normal raw word follows the used source lines only
  a_raw_follows: assert property (
    (raw_n & ~32'h0000_0003) == (SRC_REQ_I & `DLIC_SRC_MASK))
    else $error("raw status not source lines");

  // the summary bit of the normal set matches the standard fast line
  a_fiq_summary: assert property (CE_I && !nest_f |=>
    FIQ_O == $past(msk_n[0])) else $error("summary bit not fast line");

  // an active fast source also raises the standard normal line
  a_std_fast_irq: assert property (CE_I && !nest_n && fast_any |=>
    IRQ_O) else $error("fast source missing from irq");

  // a pending level no better than the one in service stays quiet
  a_irq_held_off: assert property (
    CE_I && nest_n && {1'b0, best_n.level} >= cur_n |=> !IRQ_O)
    else $error("nested request did not wait");

endmodule : dlic_top

// ### sim/dlic_src_model.sv
// peripheral request lines seen by the interrupt controller
`timescale 1ns/1ps
`include "dlic_cfg.svh"
module dlic_src_model (
  input  wire logic        clk_i,    // system clock
  input  wire logic        rst_n_i,  // async reset, active low
  input  wire logic [31:0] want_i,   // requests the bench asks for
  output logic      [31:0] line_o    // request lines to the design
);
  logic [31:0] noise;  // churns unused bits so they never look settled

  // requests are levels held until the bench changes them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      noise  <= 32'h0000_0000;
      line_o <= 32'h0000_0000;
    end else begin
      noise  <= ~noise;
      // unused positions carry garbage the design must ignore
      line_o <= (want_i & `DLIC_SRC_MASK) | (noise & ~`DLIC_SRC_MASK);
    end
  end
endmodule : dlic_src_model

// ### sim/dlic_top_tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "dlic_cfg.svh"
module dlic_top_tb_top;
  import dlic_pkg::*;
  logic          clk;         // system clock
  logic          rst_n;       // reset, active low
  logic          ce;          // clock enable
  dlic_apb_req_t req;         // apb request
  logic [31:0]   want, src;   // asked and driven request lines
  logic [31:0]   prdata;      // read data
  logic          pready, perr, irq, fiq;
  logic [31:0]   seed, rd, n_en, f_en, pgm, d;
  logic          e;
  int            error_cnt, checks, op;

  dlic_top uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .APB_I(req),
    .SRC_REQ_I(src), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(perr), .IRQ_O(irq), .FIQ_O(fiq));
  dlic_src_model srcs (.clk_i(clk), .rst_n_i(rst_n), .want_i(want),
    .line_o(src));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; waits for ready, the watchdog bounds the wait
  task automatic apb(input logic w, input logic [31:0] a, dat);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: dat};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e  = perr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // compare every status and mask register against the model
  task automatic cmp_all();
    logic [31:0] s, fm, fr, nr, nm;
    logic        fa;
    s  = want & `DLIC_SRC_MASK;
    fm = (s & f_en) | {29'h0, pgm[2], 1'b0};
    fa = |fm[31:1];
    fr = s | {29'h0, pgm[2], 1'b0} | {31'h0, fa};
    nr = s | {29'h0, pgm[1], 1'b0} | {31'h0, fa};
    nm = (s & n_en) | {29'h0, pgm[1], 1'b0} | {31'h0, fa};
    apb(1'b0, `DLIC_A_N_RAW, 32'h0);  chk(rd, nr);
    apb(1'b0, `DLIC_A_N_MSTA, 32'h0); chk(rd, nm);
    apb(1'b0, `DLIC_A_N_EN, 32'h0);   chk(rd, n_en);
    apb(1'b0, `DLIC_A_F_RAW, 32'h0);  chk(rd, fr);
    apb(1'b0, `DLIC_A_F_MSTA, 32'h0); chk(rd, fm | {31'h0, fa});
    apb(1'b0, `DLIC_A_F_EN, 32'h0);   chk(rd, f_en);
    chk({31'h0, fiq}, {31'h0, fa});
    chk({31'h0, irq}, {31'h0, |nm});
  endtask : cmp_all

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // watchdog: the whole run needs well under this span
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    error_cnt = 0;
    checks = 0;
    seed = 32'hc60e;
    rst_n = 1'b0;
    ce = 1'b1;
    want = 32'h0;
    req = '0;
    n_en = 32'h0;
    f_en = 32'h0;
    pgm = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cmp_all();
    // unmapped place answers with an error
    apb(1'b0, 32'hffff_0200, 32'h0);
    chk({31'h0, e}, 32'h1);
    // random enable, clear, programmed-config and read-only writes, sources changing meanwhile
    for (int i = 0; i < 36; i++) begin
      op = i % 6;
      d  = xs();
      want <= xs();
      case (op)
        0: begin  // set ones, other path drops them
          d &= `DLIC_SRC_MASK;
          apb(1'b1, `DLIC_A_N_EN, d);
          n_en |= d;
          f_en &= ~d;
        end
        1: begin
          d &= `DLIC_SRC_MASK;
          apb(1'b1, `DLIC_A_F_EN, d);
          f_en |= d;
          n_en &= ~d;
        end
        2: begin
          apb(1'b1, `DLIC_A_N_CLR, d);
          n_en &= ~d;
        end
        3: begin
          apb(1'b1, `DLIC_A_F_CLR, d);
          f_en &= ~d;
        end
        4: begin
          apb(1'b1, `DLIC_A_PGM, d);
          pgm = d & `DLIC_PGM_WMASK;
        end
        default: apb(1'b1, `DLIC_A_N_RAW, d);  // read-only write ignored
      endcase
      chk({31'h0, e}, 32'h0);
      cmp_all();
    end
    // vectored normal handling: uart outranks timer 0, fast beats both
    apb(1'b1, `DLIC_A_N_CLR, 32'hffff_ffff);
    apb(1'b1, `DLIC_A_F_CLR, 32'hffff_ffff);
    apb(1'b1, `DLIC_A_PGM, 32'h0000_0000);
    apb(1'b1, `DLIC_A_PRIO0, 32'h0000_5000);
    apb(1'b1, `DLIC_A_PRIO1, 32'h0000_2000);
    apb(1'b1, `DLIC_A_VBASE, 32'h0000_1234);
    apb(1'b1, `DLIC_A_N_EN, 32'h0000_0808);
    want <= 32'h0000_1808;
    pgm  = 32'h0000_0000;
    n_en = 32'h0000_0808;
    f_en = 32'h0000_0000;
    apb(1'b1, `DLIC_A_NEST, 32'h0000_0001);
    apb(1'b0, `DLIC_A_PRIO1, 32'h0);
    chk(rd, 32'h0000_2000);
    apb(1'b0, `DLIC_A_NEST, 32'h0);
    chk(rd, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1);
    // handler entry takes both masked words first
    apb(1'b0, `DLIC_A_N_MSTA, 32'h0);
    chk(rd, 32'h0000_0808);
    apb(1'b0, `DLIC_A_F_MSTA, 32'h0);
    chk(rd, 32'h0000_0000);
    d = (32'h0000_1234 << `DLIC_VEC_BASE_LSB)
      | (32'h0000_000b << `DLIC_VEC_IDX_LSB);  // uart is bit 11
    apb(1'b0, `DLIC_A_N_VEC, 32'h0);
    chk(rd, d);
    // level 2 now in service: the same level must wait
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `DLIC_A_N_VEC, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    // a fast source silences the nested normal line
    apb(1'b1, `DLIC_A_F_EN, 32'h0000_1000);
    f_en = 32'h0000_1000;
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, fiq}, 32'h1);
    apb(1'b1, `DLIC_A_NEST, 32'h0);
    cmp_all();
    tally_and_finish();
  end
endmodule : dlic_top_tb_top
